/* hw/asdec_defs.vh */
`ifndef ASDEC_DEFS_VH
`define ASDEC_DEFS_VH
`define SP_FREE1 8'h01
`define SP_FREE2 8'h02
`define SP_IODIAG 8'h07
`define SP_UINSTR 8'h08
`define SP_SDATA 8'h0B
`define SP_ITAG 8'h0C
`define SP_DDAT 8'h0F
`define SP_FLID_LO 8'h10
`define SP_FLID_HI 8'h14
`define SP_COPY 8'h17
`define SP_FLI_LO 8'h18
`define SP_FLI_HI 8'h1C
`define SP_FILL 8'h1F
`define SP_PASS_LO 8'h20
`define SP_PASS_HI 8'h2F
`define SP_FREE_LO 8'h30
`define SP_FREE_HI 8'h7F
`define CL_RSVD 4'h0
`define CL_FETCH 4'h1
`define CL_CDIAG 4'h2
`define CL_FLID 4'h3
`define CL_FLI 4'h4
`define CL_COPY 4'h5
`define CL_FILL 4'h6
`define CL_PASS 4'h7
`define CL_IODIAG 4'h8
`define CL_FREE 4'h9
`define FT_PAGE 3'h0
`define FT_SEG 3'h1
`define FT_REG 3'h2
`define FT_CTX 3'h3
`define FT_USER 3'h4
`define MASK_PAGE 32'hFFFFF000
`define MASK_SEG 32'hFFFC0000
`define MASK_REG 32'hFF000000
`define MASK_NONE 32'h00000000
`define TG_MEM 2'h0
`define TG_CDIAG 2'h1
`define TG_FLUSH 2'h2
`define TG_IODIAG 2'h3
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_COPY_RD 3'h2
`define OP_COPY_WR 3'h3
`define OP_FILL 3'h4
`define OP_PROBE 3'h5
`define VA_DUAL 31
`define VA_PROBE 12
`define PA_HI_ZERO 4'h0
`define REG_CTRL 4'h0
`define REG_CTX 4'h4
`define REG_STAT 4'h8
`define REG_ERRCNT 4'hC
`define CTRL_COPY_INV 0
`define CTRL_FILL_UPD 1
`define CTRL_RESET 32'h00000003
`define STAT_BUSY 0
`define STAT_ARMED 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hw/asdec_space_decode.v */
`include "asdec_defs.vh"
module asdec_space_decode (
  // Space identifier in.
  input wire [7:0] space_id,
  // Function class out.
  output reg [3:0] space_class
);
  // Every identifier bit takes part in each comparison.
  always @* begin
    space_class = `CL_RSVD; // see RULE1 see RULE19
    if (space_id == `SP_IODIAG) begin
      space_class = `CL_IODIAG; // see RULE2
    end else if (space_id >= `SP_UINSTR && space_id <= `SP_SDATA) begin
      space_class = `CL_FETCH; // see RULE3
    end else if (space_id >= `SP_ITAG && space_id <= `SP_DDAT) begin
      space_class = `CL_CDIAG; // see RULE4 see RULE6 see RULE7 see RULE8
    end else if (space_id >= `SP_FLID_LO && space_id <= `SP_FLID_HI) begin
      space_class = `CL_FLID; // see RULE9
    end else if (space_id == `SP_COPY) begin
      space_class = `CL_COPY; // see RULE12
    end else if (space_id >= `SP_FLI_LO && space_id <= `SP_FLI_HI) begin
      space_class = `CL_FLI; // see RULE14
    end else if (space_id == `SP_FILL) begin
      space_class = `CL_FILL; // see RULE15
    end else if (space_id >= `SP_PASS_LO && space_id <= `SP_PASS_HI) begin
      space_class = `CL_PASS; // see RULE16
    end else if (space_id >= `SP_FREE_LO && space_id <= `SP_FREE_HI) begin
      space_class = `CL_FREE; // see RULE18
    end else if (space_id == `SP_FREE1 || space_id == `SP_FREE2) begin
      space_class = `CL_FREE;
    end
  end
endmodule

/* hw/asdec_flush_fmt.v */
`include "asdec_defs.vh"
module asdec_flush_fmt (
  // Flush type in.
  input wire [2:0] flush_type,
  // Compare criteria out.
  output reg [31:0] tag_mask,
  output reg need_sup_or_ctx,
  output reg need_user,
  output reg need_ctx
);
  // Turns a flush type into the terms a cache line must meet.
  always @* begin
    tag_mask = `MASK_NONE;
    need_sup_or_ctx = 1'b0;
    need_user = 1'b0;
    need_ctx = 1'b0;
    case (flush_type)
      `FT_PAGE: begin
        tag_mask = `MASK_PAGE; // see RULE10
        need_sup_or_ctx = 1'b1;
      end
      `FT_SEG: begin
        tag_mask = `MASK_SEG; // see RULE10
        need_sup_or_ctx = 1'b1;
      end
      `FT_REG: begin
        tag_mask = `MASK_REG; // see RULE10
        need_sup_or_ctx = 1'b1;
      end
      `FT_CTX: begin
        need_user = 1'b1; // see RULE11
        need_ctx = 1'b1;
      end
      `FT_USER: begin
        need_user = 1'b1; // see RULE11
      end
      default: begin
        tag_mask = `MASK_NONE;
      end
    endcase
  end
endmodule

/* hw/asdec_dispatch.v */
// Behaviour
// RULE1: Decode all eight identifier bits so no space aliases another.
// RULE2: Space 7 reads, writes or probes an I/O translation cache entry.
// RULE3: Spaces 8, 9, A, B are user/supervisor instruction and data spaces.
// RULE4: Space C reads or writes an instruction cache tag.
// RULE5: Address bits 3:2 pick a tag subfield, bit 31 a dual tag.
// RULE6: Space D reads or writes instruction cache data.
// RULE7: Space E reads or writes a data or combined cache tag.
// RULE8: Space F reads or writes data or combined cache data.
// RULE9: Stores to 10..14 flush one matching line from both caches.
// RULE10: Low identifier bits give flush type; page, segment, region tag widths.
// RULE11: Context type needs user line and context match; user type user only.
// RULE12: Block copy is a copy read followed by a copy write.
// RULE13: Copy source memory or cache; destination memory, data cache invalidated.
// RULE14: Stores to 18..1C flush one line from the instruction cache only.
// RULE15: Block fill sets a memory line; data cache line updated or invalidated.
// RULE16: Spaces 20..2F form physical address from identifier low bits and address.
// RULE17: Pass-through accesses leave referenced and modified bits untouched.
// RULE18: Spaces 30..7F have no function here and are left free.
// RULE19: Spaces 80..FF are reserved and get no function.
// RULE20: Loads to write-only spaces complete with no side effect.
`include "asdec_defs.vh"
module asdec_dispatch #(
  parameter CTX_W = 8,
  parameter ERRCNT_W = 16
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register slave.
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [3:0] s_axi_araddr,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Alternate-space requests from the core.
  input wire req_valid,
  output wire req_ready,
  input wire [7:0] req_space_id,
  input wire [31:0] req_vaddr,
  input wire req_write,
  input wire [31:0] req_wdata,
  // Answers to the core.
  output wire rsp_valid,
  output wire [31:0] rsp_rdata,
  output wire rsp_err,
  // Operation towards caches, translation caches and memory.
  output wire dn_valid,
  input wire dn_ready,
  output wire [1:0] dn_target,
  output wire [2:0] dn_op,
  output wire [35:0] dn_paddr,
  output wire [31:0] dn_wdata,
  output wire dn_translate,
  output wire dn_supervisor,
  output wire dn_instr,
  output wire dn_no_refmod,
  output wire [1:0] dn_cache_sel,
  output wire [1:0] dn_tag_sub,
  output wire dn_tag_dual,
  output wire dn_flush_icache,
  output wire dn_flush_dcache,
  output wire [2:0] dn_flush_type,
  output wire [CTX_W-1:0] dn_context,
  output wire [31:0] dn_tag_mask,
  output wire dn_need_sup_or_ctx,
  output wire dn_need_user,
  output wire dn_need_ctx,
  output wire dn_dc_inval,
  output wire dn_dc_update,
  // Completion from the far side.
  input wire dn_done,
  input wire [31:0] dn_rdata,
  input wire dn_err
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ISSUE = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_RESP = 2'h3;

  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [3:0] space_class;
  wire [31:0] fl_mask;
  wire fl_sup_or_ctx;
  wire fl_user;
  wire fl_ctx;

  asdec_space_decode u_decode (
    .space_id(req_space_id),
    .space_class(space_class)
  );

  asdec_flush_fmt u_flush (
    .flush_type(req_space_id[2:0]),
    .tag_mask(fl_mask),
    .need_sup_or_ctx(fl_sup_or_ctx),
    .need_user(fl_user),
    .need_ctx(fl_ctx)
  );

  reg [1:0] state_q;
  reg [31:0] ctrl_q;
  reg [CTX_W-1:0] ctx_q;
  reg [ERRCNT_W-1:0] errcnt_q;
  reg armed_q;
  reg [31:0] rsp_rdata_q;
  reg rsp_err_q;
  reg [1:0] target_q;
  reg [2:0] op_q;
  reg [35:0] paddr_q;
  reg [31:0] wdata_q;
  reg translate_q;
  reg supervisor_q;
  reg instr_q;
  reg no_refmod_q;
  reg [1:0] cache_sel_q;
  reg [1:0] tag_sub_q;
  reg tag_dual_q;
  reg flush_i_q;
  reg flush_d_q;
  reg [2:0] flush_type_q;
  reg [CTX_W-1:0] context_q;
  reg [31:0] tag_mask_q;
  reg need_soc_q;
  reg need_user_q;
  reg need_ctx_q;
  reg dc_inval_q;
  reg dc_update_q;

  wire accept = req_valid && state_q == ST_IDLE;
  reg go_d;
  reg err_d;

  // Requests that do nothing but answer, with or without error.
  always @* begin
    go_d = 1'b1;
    err_d = 1'b0;
    case (space_class)
      `CL_FLID, `CL_FLI, `CL_FILL: begin
        go_d = req_write; // see RULE20
      end
      `CL_COPY: begin
        go_d = !req_write || armed_q; // see RULE12
        err_d = req_write && !armed_q;
      end
      `CL_FREE, `CL_RSVD: begin
        go_d = 1'b0; // see RULE18 see RULE19
        err_d = 1'b1;
      end
      default: begin
        go_d = 1'b1;
      end
    endcase
  end

  wire err_evt = accept && err_d;

  // Request sequencing and operation build-up.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      rsp_rdata_q <= 32'h00000000;
      rsp_err_q <= 1'b0;
      target_q <= `TG_MEM;
      op_q <= `OP_READ;
      paddr_q <= 36'h000000000;
      wdata_q <= 32'h00000000;
      translate_q <= 1'b0;
      supervisor_q <= 1'b0;
      instr_q <= 1'b0;
      no_refmod_q <= 1'b0;
      cache_sel_q <= 2'h0;
      tag_sub_q <= 2'h0;
      tag_dual_q <= 1'b0;
      flush_i_q <= 1'b0;
      flush_d_q <= 1'b0;
      flush_type_q <= `FT_PAGE;
      context_q <= {CTX_W{1'b0}};
      tag_mask_q <= `MASK_NONE;
      need_soc_q <= 1'b0;
      need_user_q <= 1'b0;
      need_ctx_q <= 1'b0;
      dc_inval_q <= 1'b0;
      dc_update_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            rsp_rdata_q <= 32'h00000000;
            rsp_err_q <= err_d;
            state_q <= go_d ? ST_ISSUE : ST_RESP;
            paddr_q <= {`PA_HI_ZERO, req_vaddr};
            wdata_q <= req_wdata;
            op_q <= req_write ? `OP_WRITE : `OP_READ;
            target_q <= `TG_MEM;
            translate_q <= 1'b0;
            supervisor_q <= req_space_id[0];
            instr_q <= 1'b0;
            no_refmod_q <= 1'b0;
            cache_sel_q <= req_space_id[1:0];
            tag_sub_q <= req_vaddr[3:2]; // see RULE5
            tag_dual_q <= req_vaddr[`VA_DUAL]; // see RULE5
            flush_i_q <= 1'b0;
            flush_d_q <= 1'b0;
            flush_type_q <= req_space_id[2:0]; // see RULE10
            context_q <= ctx_q; // see RULE11
            tag_mask_q <= fl_mask;
            need_soc_q <= fl_sup_or_ctx;
            need_user_q <= fl_user;
            need_ctx_q <= fl_ctx;
            dc_inval_q <= 1'b0;
            dc_update_q <= 1'b0;
            case (space_class)
              `CL_FETCH: begin
                translate_q <= 1'b1; // see RULE3
                instr_q <= !req_space_id[1];
              end
              `CL_CDIAG: begin
                target_q <= `TG_CDIAG; // see RULE4 see RULE6 see RULE7 see RULE8
              end
              `CL_IODIAG: begin
                target_q <= `TG_IODIAG; // see RULE2
                if (!req_write && req_vaddr[`VA_PROBE]) begin
                  op_q <= `OP_PROBE;
                end
              end
              `CL_FLID: begin
                target_q <= `TG_FLUSH; // see RULE9
                flush_i_q <= 1'b1;
                flush_d_q <= 1'b1;
              end
              `CL_FLI: begin
                target_q <= `TG_FLUSH; // see RULE14
                flush_i_q <= 1'b1;
              end
              `CL_COPY: begin
                op_q <= req_write ? `OP_COPY_WR : `OP_COPY_RD; // see RULE12
                dc_inval_q <= req_write && ctrl_q[`CTRL_COPY_INV]; // see RULE13
              end
              `CL_FILL: begin
                op_q <= `OP_FILL; // see RULE15
                dc_update_q <= ctrl_q[`CTRL_FILL_UPD];
                dc_inval_q <= !ctrl_q[`CTRL_FILL_UPD];
              end
              `CL_PASS: begin
                paddr_q <= {req_space_id[3:0], req_vaddr}; // see RULE16
                no_refmod_q <= 1'b1; // see RULE17
              end
              default: begin
                target_q <= `TG_MEM;
              end
            endcase
          end
        end
        ST_ISSUE: begin
          if (dn_ready) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (dn_done) begin
            rsp_rdata_q <= dn_rdata;
            rsp_err_q <= dn_err;
            state_q <= ST_RESP;
          end
        end
        ST_RESP: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // A copy read arms the copy write; the write disarms it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
    end else if (state_q == ST_WAIT && dn_done && target_q == `TG_MEM) begin
      if (op_q == `OP_COPY_RD && !dn_err) begin
        armed_q <= 1'b1; // see RULE12 see RULE13
      end else if (op_q == `OP_COPY_WR) begin
        armed_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite slave, one write and one read at a time.
  reg aw_q;
  reg w_q;
  reg [3:0] awaddr_q;
  reg [31:0] axi_wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire wr_go = aw_q && w_q && !bvalid_q;
  wire errcnt_clr = wr_go && awaddr_q == `REG_ERRCNT;
  wire [31:0] ctx_merge = strb_merge({{(32-CTX_W){1'b0}}, ctx_q}, axi_wdata_q, wstrb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 4'h0;
      axi_wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      ctrl_q <= `CTRL_RESET;
      ctx_q <= {CTX_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        axi_wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= `RESP_OKAY;
        case (awaddr_q)
          `REG_CTRL: ctrl_q <= strb_merge(ctrl_q, axi_wdata_q, wstrb_q);
          `REG_CTX: ctx_q <= ctx_merge[CTX_W-1:0];
          `REG_STAT, `REG_ERRCNT: bresp_q <= `RESP_OKAY;
          default: bresp_q <= `RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Error counter; an error in the clearing cycle still counts.
  always @(posedge aclk) begin
    if (!aresetn) begin
      errcnt_q <= {ERRCNT_W{1'b0}};
    end else if (errcnt_clr) begin
      errcnt_q <= err_evt ? {{(ERRCNT_W-1){1'b0}}, 1'b1} : {ERRCNT_W{1'b0}};
    end else if (err_evt) begin
      errcnt_q <= errcnt_q + {{(ERRCNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h00000000;
      case (s_axi_araddr)
        `REG_CTRL: rdata_q <= ctrl_q;
        `REG_CTX: rdata_q <= {{(32-CTX_W){1'b0}}, ctx_q};
        `REG_STAT: begin
          rdata_q[`STAT_BUSY] <= state_q != ST_IDLE;
          rdata_q[`STAT_ARMED] <= armed_q;
        end
        `REG_ERRCNT: rdata_q <= {{(32-ERRCNT_W){1'b0}}, errcnt_q};
        default: rresp_q <= `RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  assign req_ready = state_q == ST_IDLE;
  assign rsp_valid = state_q == ST_RESP;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_err = rsp_err_q;
  assign dn_valid = state_q == ST_ISSUE;
  assign dn_target = target_q;
  assign dn_op = op_q;
  assign dn_paddr = paddr_q;
  assign dn_wdata = wdata_q;
  assign dn_translate = translate_q;
  assign dn_supervisor = supervisor_q;
  assign dn_instr = instr_q;
  assign dn_no_refmod = no_refmod_q;
  assign dn_cache_sel = cache_sel_q;
  assign dn_tag_sub = tag_sub_q;
  assign dn_tag_dual = tag_dual_q;
  assign dn_flush_icache = flush_i_q;
  assign dn_flush_dcache = flush_d_q;
  assign dn_flush_type = flush_type_q;
  assign dn_context = context_q;
  assign dn_tag_mask = tag_mask_q;
  assign dn_need_sup_or_ctx = need_soc_q;
  assign dn_need_user = need_user_q;
  assign dn_need_ctx = need_ctx_q;
  assign dn_dc_inval = dc_inval_q;
  assign dn_dc_update = dc_update_q;
endmodule

/* dv/asdec_dispatch_sva.sv */
`include "asdec_defs.vh"
module asdec_dispatch_sva (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Core request and answer.
  input wire req_valid,
  input wire req_ready,
  input wire [7:0] req_space_id,
  input wire [31:0] req_vaddr,
  input wire req_write,
  input wire rsp_valid,
  input wire rsp_err,
  input wire [31:0] rsp_rdata,
  // Operation towards the far side.
  input wire dn_valid,
  input wire [1:0] dn_target,
  input wire [35:0] dn_paddr,
  input wire dn_no_refmod,
  input wire dn_flush_icache,
  input wire dn_flush_dcache,
  input wire [2:0] dn_flush_type,
  input wire [31:0] dn_tag_mask,
  input wire dn_need_user,
  input wire dn_need_ctx
);
  timeunit 1ns;
  timeprecision 1ps;
  wire acc = req_valid && req_ready;
  wire [7:0] sp = req_space_id;
  wire fl = dn_valid && dn_target == `TG_FLUSH;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pass;
    acc && sp[7:4] == 4'h2 |=> dn_valid && dn_no_refmod && dn_paddr == {$past(sp[3:0]), $past(req_vaddr)};
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through address wrong");
  property p_rsvd;
    acc && sp[7] |=> rsp_valid && rsp_err && !dn_valid;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved space not refused");
  property p_free;
    acc && sp >= 8'h30 && sp <= 8'h7F |-> ##1 (rsp_valid && rsp_err && !dn_valid);
  endproperty
  a_free: assert property (p_free) else $error("free space dispatched");
  property p_flid;
    acc && req_write && sp >= 8'h10 && sp <= 8'h14 |=> fl && dn_flush_icache && dn_flush_dcache && dn_flush_type == $past(sp[2:0]);
  endproperty
  a_flid: assert property (p_flid) else $error("combined flush wrong");
  property p_fli;
    acc && req_write && sp >= 8'h18 && sp <= 8'h1C |=> fl && dn_flush_icache && !dn_flush_dcache;
  endproperty
  a_fli: assert property (p_fli) else $error("instruction flush wrong");
  property p_mask;
    fl |-> dn_tag_mask == (dn_flush_type == `FT_PAGE ? `MASK_PAGE : dn_flush_type == `FT_SEG ? `MASK_SEG :
      dn_flush_type == `FT_REG ? `MASK_REG : `MASK_NONE);
  endproperty
  a_mask: assert property (p_mask) else $error("flush tag mask wrong");
  property p_ctx;
    fl && dn_flush_type >= `FT_CTX |-> dn_need_user && (dn_need_ctx == (dn_flush_type == `FT_CTX));
  endproperty
  a_ctx: assert property (p_ctx) else $error("flush criteria wrong");
  property p_ldfl;
    acc && !req_write && sp[7:4] == 4'h1 && (sp[2:0] <= 3'h4 || sp[3:0] == 4'hF) |=>
      rsp_valid && !rsp_err && rsp_rdata == 32'h0 && !dn_valid;
  endproperty
  a_ldfl: assert property (p_ldfl) else $error("load to write-only space acted");
endmodule
bind asdec_dispatch asdec_dispatch_sva u_sva (.aclk, .aresetn, .req_valid, .req_ready, .req_space_id, .req_vaddr,
  .req_write, .rsp_valid, .rsp_err, .rsp_rdata, .dn_valid, .dn_target, .dn_paddr, .dn_no_refmod, .dn_flush_icache,
  .dn_flush_dcache, .dn_flush_type, .dn_tag_mask, .dn_need_user, .dn_need_ctx);

/* dv/asdec_far_model.sv */
module asdec_far_model #(
  parameter logic [31:0] RD_PAT = 32'h0
) (
  // Clock, reset and pacing.
  input wire aclk,
  input wire aresetn,
  input wire [3:0] lag,
  // Operation handshake and completion.
  input wire dn_valid,
  input wire [2:0] dn_op,
  output logic dn_ready,
  output logic dn_done,
  output logic [31:0] dn_rdata,
  output logic dn_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic pend_q;
  assign dn_err = 1'b0;
  // Read data toggles outside the completion cycle so stale capture shows.
  always @(posedge aclk) begin
    dn_done <= 1'b0;
    dn_rdata <= ~dn_rdata;
    if (!aresetn) begin
      dn_ready <= 1'b0;
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      dn_rdata <= 32'h0;
    end else if (dn_valid && dn_ready) begin
      dn_ready <= 1'b0;
      pend_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (cnt_q != lag) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (pend_q) begin
      dn_done <= 1'b1;
      dn_rdata <= RD_PAT | {29'h0, dn_op};
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (dn_valid) begin
      dn_ready <= 1'b1;
    end
  end
endmodule

/* dv/asdec_dispatch_test.sv */
`include "asdec_defs.vh"
module asdec_dispatch_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'h3C5A96E0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, req_valid, req_write, went;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, lag;
  logic [31:0] s_axi_wdata, req_vaddr, req_wdata, rd;
  logic [7:0] req_space_id;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready, rsp_valid, rsp_err;
  wire dn_valid, dn_ready, dn_translate, dn_supervisor, dn_instr, dn_no_refmod, dn_tag_dual, dn_flush_icache;
  wire dn_flush_dcache, dn_need_sup_or_ctx, dn_need_user, dn_need_ctx, dn_dc_inval, dn_dc_update, dn_done, dn_err;
  wire [1:0] s_axi_bresp, s_axi_rresp, dn_target, dn_cache_sel, dn_tag_sub;
  wire [31:0] s_axi_rdata, rsp_rdata, dn_wdata, dn_tag_mask, dn_rdata;
  wire [2:0] dn_op, dn_flush_type;
  wire [35:0] dn_paddr;
  wire [7:0] dn_context;
  int n_fail = 0;
  int total_checks = 0;
  int n_dn = 0;
  asdec_dispatch dut (.*);
  asdec_far_model #(.RD_PAT(PAT)) far (.*);
  always #2 aclk = ~aclk;
  always @(posedge aclk) if (dn_valid && dn_ready) n_dn <= n_dn + 1;
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 100);
    if (n >= 100) n_fail++;
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic core(input logic [7:0] id, input logic [31:0] va, input logic wr);
    int n;
    int d0;
    d0 = n_dn;
    n = 0;
    req_valid <= 1'b1;
    req_space_id <= id;
    req_vaddr <= va;
    req_write <= wr;
    req_wdata <= ~va;
    do begin
      @(posedge aclk);
      n++;
    end while (!req_ready && n < 100);
    req_valid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rsp_valid && n < 200);
    if (n >= 200) n_fail++;
    went = (n_dn != d0);
  endtask
  task automatic t_regs();
    axi(0, `REG_CTRL, 0);
    chk({2'h0, rs, rd}, {2'h0, `RESP_OKAY, `CTRL_RESET});
    axi(1, `REG_CTX, 32'h5A);
    axi(0, `REG_CTX, 0);
    chk({2'h0, rs, rd}, {2'h0, `RESP_OKAY, 32'h5A});
    axi(0, 4'h2, 0);
    chk({2'h0, rs, rd}, {2'h0, `RESP_SLVERR, 32'h0});
  endtask
  task automatic t_space();
    for (int i = 8; i < 12; i++) begin
      core(8'(i), 32'h1230, 1'b0);
      chk({30'h0, went, dn_target, dn_translate, dn_supervisor, dn_instr}, {30'h0, 1'b1, `TG_MEM, 1'b1, i[0], ~i[1]});
      chk({4'h0, rsp_rdata}, {4'h0, PAT | 32'(`OP_READ)});
    end
    for (int i = 12; i < 16; i++) begin
      core(8'(i), 32'h80000008, 1'b1);
      chk({25'h0, went, dn_target, dn_op, dn_cache_sel, dn_tag_sub, dn_tag_dual},
        {25'h0, 1'b1, `TG_CDIAG, `OP_WRITE, i[1:0], 2'h2, 1'b1});
    end
    for (int k = 0; k < 3; k++) begin
      core(`SP_IODIAG, k == 0 ? 32'h1000 : 32'h0, k == 2);
      chk({29'h0, went, dn_target, dn_op, rsp_err},
        {29'h0, 1'b1, `TG_IODIAG, k == 0 ? `OP_PROBE : k == 1 ? `OP_READ : `OP_WRITE, 1'b0});
    end
  endtask
  task automatic t_flush();
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 5; i++) begin
        core(8'h10 + 8'(8 * b + i), 32'hFFFFFFFF, 1'b1);
        chk({28'h0, went, dn_target, dn_flush_icache, dn_flush_dcache, dn_flush_type},
          {28'h0, 1'b1, `TG_FLUSH, 1'b1, b == 0, 3'(i)});
        chk({4'h0, dn_tag_mask}, {4'h0, i == 0 ? `MASK_PAGE : i == 1 ? `MASK_SEG : i == 2 ? `MASK_REG : `MASK_NONE});
        chk({25'h0, dn_need_sup_or_ctx, dn_need_user, dn_need_ctx, dn_context}, {25'h0, i < 3, i > 2, i == 3, 8'h5A});
        core(8'h10 + 8'(8 * b + i), 32'hFFFFFFFF, 1'b0);
        chk({2'h0, went, rsp_err, rsp_rdata}, 36'h0);
      end
    end
  endtask
  task automatic t_bad();
    logic [7:0] ids [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h15, 8'h16, 8'h1D, 8'h1E, 8'h30, 8'h7F, 8'h80,
      8'h97, 8'hA0, 8'hFF};
    axi(1, `REG_ERRCNT, 0);
    foreach (ids[k]) begin
      core(ids[k], 32'h0, 1'b0);
      chk({34'h0, went, rsp_err}, 36'h1);
    end
    axi(0, `REG_ERRCNT, 0);
    chk({4'h0, rd}, 36'd15);
  endtask
  task automatic t_copy_fill();
    core(`SP_COPY, 32'h100, 1'b1);
    chk({34'h0, went, rsp_err}, 36'h1);
    core(`SP_COPY, 32'h100, 1'b0);
    chk({went, dn_op, rsp_rdata}, {1'b1, `OP_COPY_RD, PAT | 32'(`OP_COPY_RD)});
    core(`SP_COPY, 32'h200, 1'b1);
    chk({28'h0, went, rsp_err, dn_target, dn_op, dn_dc_inval}, {28'h0, 2'b10, `TG_MEM, `OP_COPY_WR, 1'b1});
    core(`SP_COPY, 32'h200, 1'b1);
    chk({34'h0, went, rsp_err}, 36'h1);
    core(`SP_FILL, 32'h300, 1'b1);
    chk({went, dn_op, dn_wdata}, {1'b1, `OP_FILL, ~32'h300});
    chk({34'h0, dn_dc_update, dn_dc_inval}, 36'h2);
    axi(1, `REG_CTRL, 1);
    core(`SP_FILL, 32'h300, 1'b1);
    chk({34'h0, dn_dc_update, dn_dc_inval}, 36'h1);
  endtask
  task automatic t_pass();
    lag <= 4'h3;
    for (int i = 0; i < 16; i++) begin
      core(8'h20 + 8'(i), 32'hC0DE0000 + 32'(i), i[0]);
      chk(dn_paddr, {4'(i), 32'hC0DE0000 + 32'(i)});
      chk({31'h0, went, dn_no_refmod, dn_target, dn_translate}, {31'h0, 2'b11, `TG_MEM, 1'b0});
    end
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {req_valid, req_write, req_space_id, req_vaddr, req_wdata, lag} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_space();
    t_flush();
    t_bad();
    t_copy_fill();
    t_pass();
    complete_run();
  end
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
